/* hdl/mobile_ddr_cmd_addr_frontend.v */
// command/address front end and burst sequencer
// assumes link pins asynchronous to sys_clk, link clock well below sys_clk/4
`timescale 1ns/1ps
`include "lpddr_fe_defines.vh"

module mobile_ddr_cmd_addr_frontend (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // link pins
    input wire ck_t,
    input wire ck_c,
    input wire cke,
    input wire cs_n,
    input wire [`CA_W-1:0] cmd_addr_bus,
    input wire [`DM_W-1:0] write_byte_mask,
    input wire speed_grade,
    // configuration
    input wire dual_die,
    // strobe pin
    output reg dqs_out,
    output reg dqs_oe,
    // core access
    output reg core_rd,
    output reg core_wr,
    output reg [`BANK_W-1:0] core_bank,
    output reg [`ROW_W-1:0] core_row,
    output reg [`COL_W-1:0] core_col,
    // pin beats
    output reg beat_valid,
    output reg beat_write,
    output reg [`COL_W-1:0] beat_col,
    output reg [`DM_W-1:0] beat_byte_en,
    // status
    output reg clocks_active,
    output reg power_down,
    output reg cmd_error,
    output reg burst_busy,
    output reg [3:0] read_latency,
    output reg [2:0] write_latency,
    output reg [4:0] burst_length,
    output reg burst_interleave
);

localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_BURST = 3'b100;
localparam SYNC_W = 2 + 2 + `CA_W + `DM_W + 1;

// column of beat i within a wrapped burst
function [`COL_W-1:0] burst_col;
    input [`COL_W-1:0] start;
    input [3:0] i;
    input [4:0] bl;
    input il;
    reg [3:0] m;
    reg [3:0] lo;
    begin
        m = bl[3:0] - 4'h1;
        lo = il ? (start[3:0] ^ i) : (start[3:0] + i);
        burst_col = (start & ~{6'h00, m}) | {6'h00, lo & m};
    end
endfunction

function rl_ok;
    input [3:0] v;
    begin
        rl_ok = (v == 4'h3) || (v == 4'h4) || (v == 4'h5) || (v == 4'h6) || (v == 4'h8);
    end
endfunction

// two-flop synchroniser on every link pin
reg [SYNC_W-1:0] sync1;
reg [SYNC_W-1:0] sync2;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        sync1 <= {SYNC_W{1'b0}};
        sync2 <= {SYNC_W{1'b0}};
    end else begin
        sync1 <= {ck_t, ck_c, cke, cs_n, cmd_addr_bus, write_byte_mask, speed_grade};
        sync2 <= sync1;
    end
end

wire s_ck_t = sync2[SYNC_W-1];
wire s_ck_c = sync2[SYNC_W-2];
wire s_cke = sync2[SYNC_W-3];
wire s_cs_n = sync2[SYNC_W-4];
wire [`CA_W-1:0] s_ca = sync2[`DM_W+`CA_W:`DM_W+1];
wire [`DM_W-1:0] s_dm = sync2[`DM_W:1];
wire s_grade = sync2[0];

// crosspoint edge detection
reg prev_t;
reg prev_c;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        prev_t <= 1'b0;
        prev_c <= 1'b1;
    end else begin
        prev_t <= s_ck_t;
        prev_c <= s_ck_c;
    end
end
wire ck_pos = s_ck_t && !s_ck_c && !prev_t && prev_c;
wire ck_neg = !s_ck_t && s_ck_c && prev_t && !prev_c;

// rising half and sdr inputs
reg rise_ok;
reg [`CA_W-1:0] ca_r;
reg cke_prev;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        rise_ok <= 1'b0;
        ca_r <= {`CA_W{1'b0}};
        cke_prev <= 1'b0;
        clocks_active <= 1'b0;
        power_down <= 1'b0;
    end else if (ck_pos) begin
        ca_r <= s_ca;
        cke_prev <= s_cke;
        rise_ok <= !s_cs_n && s_cke && cke_prev;
        clocks_active <= s_cke;
        if (cke_prev && !s_cke) begin
            power_down <= 1'b1;
        end else if (!cke_prev && s_cke) begin
            power_down <= 1'b0;
        end
    end else if (ck_neg) begin
        rise_ok <= 1'b0;
    end
end

// full command after falling half
wire cmd_stb = ck_neg && rise_ok;
wire [2:0] cmd_op = ca_r[`CA_OP_HI:`CA_OP_LO];
wire [`BANK_W-1:0] cmd_bank = ca_r[`CA_BA_HI:`CA_BA_LO];
wire [3:0] cmd_hi = ca_r[`CA_HI_HI:`CA_HI_LO];
wire [`ROW_W-1:0] cmd_row = {cmd_hi, s_ca};
wire [`COL_W-1:0] col_mask = dual_die ? `COL_MASK_DUAL : `COL_MASK_SINGLE;
wire [`COL_W-1:0] cmd_col = s_ca & col_mask;
wire [7:0] mr_op = s_ca[7:0];

// row table
reg act_we;
reg [`BANK_W-1:0] act_bank;
reg [`ROW_W-1:0] act_row;
reg [`BANK_W-1:0] pend_bank;
wire [`ROW_W-1:0] open_row;

lpddr_fe_row_table u_rows (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(act_we),
    .waddr(act_bank),
    .wdata(act_row),
    .raddr(pend_bank),
    .rdata(open_row)
);

// speed grade strap caught after reset release
reg [1:0] strap_cnt;
reg [3:0] grade_rl;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        strap_cnt <= 2'h0;
        grade_rl <= `RL_FAST;
    end else if (strap_cnt != `STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'h1;
        grade_rl <= s_grade ? `RL_SLOW : `RL_FAST;
    end
end
wire strap_ready = (strap_cnt == `STRAP_WAIT);

// sequencer
reg [2:0] state;
reg [`NBANK-1:0] bank_open;
reg [`COL_W-1:0] pend_col;
reg pend_wr;
reg [3:0] lat_cnt;
reg [3:0] beat_idx;
reg rl_set;

wire link_edge = ck_pos || ck_neg;
wire beat_edge = ((state == ST_WAIT) && ck_pos && (lat_cnt == 4'h1)) || ((state == ST_BURST) && link_edge);
wire last_beat = (beat_idx == (burst_length[3:0] - 4'h1));
wire [`COL_W-1:0] cur_col = burst_col(pend_col, beat_idx, burst_length, burst_interleave);

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        state <= ST_IDLE;
        bank_open <= {`NBANK{1'b0}};
        pend_bank <= {`BANK_W{1'b0}};
        pend_col <= {`COL_W{1'b0}};
        pend_wr <= 1'b0;
        lat_cnt <= 4'h0;
        beat_idx <= 4'h0;
        rl_set <= 1'b0;
        act_we <= 1'b0;
        act_bank <= {`BANK_W{1'b0}};
        act_row <= {`ROW_W{1'b0}};
        read_latency <= `RL_FAST;
        write_latency <= `WL_DEFAULT;
        burst_length <= `BL_4;
        burst_interleave <= 1'b0;
        cmd_error <= 1'b0;
        burst_busy <= 1'b0;
        core_rd <= 1'b0;
        core_wr <= 1'b0;
        core_bank <= {`BANK_W{1'b0}};
        core_row <= {`ROW_W{1'b0}};
        core_col <= {`COL_W{1'b0}};
        beat_valid <= 1'b0;
        beat_write <= 1'b0;
        beat_col <= {`COL_W{1'b0}};
        beat_byte_en <= {`DM_W{1'b0}};
        dqs_out <= 1'b0;
        dqs_oe <= 1'b0;
    end else begin
        act_we <= 1'b0;
        cmd_error <= 1'b0;
        core_rd <= 1'b0;
        core_wr <= 1'b0;
        beat_valid <= 1'b0;
        burst_busy <= (state != ST_IDLE);
        if (strap_ready && !rl_set) begin
            rl_set <= 1'b1;
            read_latency <= grade_rl;
        end
        if (cmd_stb) begin
            case (cmd_op)
                `OP_ACT: begin
                    bank_open[cmd_bank] <= 1'b1;
                    act_we <= 1'b1;
                    act_bank <= cmd_bank;
                    act_row <= cmd_row;
                end
                `OP_RD, `OP_WR: begin
                    if (!bank_open[cmd_bank] || (state != ST_IDLE)) begin
                        cmd_error <= 1'b1;
                    end else begin
                        pend_bank <= cmd_bank;
                        pend_col <= cmd_col;
                        pend_wr <= (cmd_op == `OP_WR);
                        lat_cnt <= (cmd_op == `OP_WR) ? {1'b0, write_latency} : read_latency;
                        beat_idx <= 4'h0;
                        state <= ST_WAIT;
                    end
                end
                `OP_MRW: begin
                    case (cmd_hi)
                        `MA_RESET: begin
                            bank_open <= {`NBANK{1'b0}};
                            read_latency <= grade_rl;
                            write_latency <= `WL_DEFAULT;
                            burst_length <= `BL_4;
                            burst_interleave <= 1'b0;
                            state <= ST_IDLE;
                        end
                        `MA_BURST: begin
                            burst_interleave <= mr_op[`BT_BIT];
                            if (mr_op[2:0] == `BL_CODE_4) begin
                                burst_length <= `BL_4;
                            end else if (mr_op[2:0] == `BL_CODE_8) begin
                                burst_length <= `BL_8;
                            end else if (mr_op[2:0] == `BL_CODE_16) begin
                                burst_length <= `BL_16;
                            end else begin
                                cmd_error <= 1'b1;
                            end
                        end
                        `MA_LAT: begin
                            if (rl_ok(mr_op[`RL_HI:`RL_LO]) && (mr_op[`WL_HI:`WL_LO] != 3'h0)
                                && (mr_op[`WL_HI:`WL_LO] <= 3'h4)) begin
                                read_latency <= mr_op[`RL_HI:`RL_LO];
                                write_latency <= mr_op[`WL_HI:`WL_LO];
                            end else begin
                                cmd_error <= 1'b1;
                            end
                        end
                        default: begin
                            cmd_error <= 1'b1;
                        end
                    endcase
                end
                `OP_NOP: begin
                end
                default: begin
                    cmd_error <= 1'b1;
                end
            endcase
        end
        if (link_edge || (state != ST_IDLE)) begin
            case (state)
                ST_IDLE: begin
                    if (link_edge) begin
                        dqs_oe <= 1'b0;
                        dqs_out <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (ck_pos) begin
                        lat_cnt <= lat_cnt - 4'h1;
                        if (lat_cnt == 4'h1) begin
                            state <= ST_BURST;
                        end
                    end
                end
                ST_BURST: begin
                    if (link_edge && last_beat) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (beat_edge) begin
                beat_valid <= 1'b1;
                beat_write <= pend_wr;
                beat_col <= cur_col;
                beat_byte_en <= pend_wr ? ~s_dm : {`DM_W{1'b1}};
                dqs_oe <= !pend_wr;
                dqs_out <= !pend_wr && !beat_idx[0];
                beat_idx <= beat_idx + 4'h1;
                if (beat_idx[1:0] == 2'h0) begin
                    core_rd <= !pend_wr;
                    core_wr <= pend_wr;
                    core_bank <= pend_bank;
                    core_row <= open_row;
                    core_col <= cur_col;
                end
            end
        end
    end
end

endmodule // mobile_ddr_cmd_addr_frontend

/* hdl/lpddr_fe_defines.vh */
// constants of the command/address front end
// assumes inclusion by the front end and its bank row table
`ifndef LPDDR_FE_DEFINES_VH
`define LPDDR_FE_DEFINES_VH

// widths
`define CA_W 10
`define BANK_W 3
`define ROW_W 14
`define COL_W 10
`define DM_W 4
`define NBANK 8

// rising-half fields
`define CA_OP_HI 2
`define CA_OP_LO 0
`define CA_BA_HI 5
`define CA_BA_LO 3
`define CA_HI_HI 9
`define CA_HI_LO 6

// opcodes in rising half
`define OP_ACT 3'h1
`define OP_WR 3'h2
`define OP_RD 3'h3
`define OP_MRW 3'h4
`define OP_NOP 3'h7

// mode register addresses and fields
`define MA_RESET 4'h0
`define MA_BURST 4'h1
`define MA_LAT 4'h2
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_CODE_16 3'h4
`define BT_BIT 3
`define RL_HI 3
`define RL_LO 0
`define WL_HI 6
`define WL_LO 4

// burst lengths
`define BL_4 5'h04
`define BL_8 5'h08
`define BL_16 5'h10

// latencies, speed grades and column masks
`define RL_FAST 4'h6
`define RL_SLOW 4'h5
`define TCK_FAST_PS 2500
`define TCK_SLOW_PS 3000
`define WL_DEFAULT 3'h3
`define COL_MASK_SINGLE 10'h1ff
`define COL_MASK_DUAL 10'h3ff
`define STRAP_WAIT 2'h3

`endif

/* hdl/lpddr_fe_row_table.v */
// open-row table, one word per bank, registered read
// assumes one write port and one read port on sys_clk
`timescale 1ns/1ps
`include "lpddr_fe_defines.vh"

module lpddr_fe_row_table (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // write port
    input wire we,
    input wire [`BANK_W-1:0] waddr,
    input wire [`ROW_W-1:0] wdata,
    // read port
    input wire [`BANK_W-1:0] raddr,
    output reg [`ROW_W-1:0] rdata
);

reg [`ROW_W-1:0] mem [0:`NBANK-1];

always @(posedge sys_clk) begin
    if (we) begin
        mem[waddr] <= wdata;
    end
end

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        rdata <= {`ROW_W{1'b0}};
    end else begin
        rdata <= mem[raddr];
    end
end

endmodule // lpddr_fe_row_table

/* dv/lpddr_fe_monitor.sv */
// concurrent checks on the front end ports
// assumes binding to the front end top module
`timescale 1ns/1ps

module lpddr_fe_monitor (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // link clock
    input wire ck_t,
    // strobe and core
    input wire dqs_out,
    input wire dqs_oe,
    input wire core_rd,
    input wire core_wr,
    // beats
    input wire beat_valid,
    input wire beat_write,
    input wire [3:0] beat_byte_en,
    // status
    input wire clocks_active,
    input wire power_down,
    input wire cmd_error,
    input wire [3:0] read_latency,
    input wire [2:0] write_latency,
    input wire [4:0] burst_length
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence rd_beat;
        beat_valid && !beat_write;
    endsequence
    sequence wr_beat;
        beat_valid && beat_write;
    endsequence
    core_read_a: assert property (core_rd |-> rd_beat)
        else $error("core read off a read beat");
    core_write_a: assert property (core_wr |-> wr_beat)
        else $error("core write off a write beat");
    core_gap_a: assert property ((core_rd || core_wr) |=> !(core_rd || core_wr) [*8])
        else $error("core transfers too close");
    beat_pulse_a: assert property (beat_valid |=> !beat_valid)
        else $error("beat longer than one cycle");
    read_strobe_a: assert property (rd_beat |-> dqs_oe && dqs_out != $past(dqs_out))
        else $error("strobe not toggling with read beat");
    write_strobe_a: assert property (wr_beat |-> !dqs_oe)
        else $error("strobe driven on write");
    read_lanes_a: assert property (rd_beat |-> beat_byte_en == 4'hf)
        else $error("read lane disabled");
    edge_sample_a: assert property ($changed({clocks_active, power_down}) |-> ck_t)
        else $error("enable state changed off positive edge");
    power_state_a: assert property (power_down |-> !clocks_active)
        else $error("power down with clocks active");
    settings_a: assert property (read_latency inside {3, 4, 5, 6, 8} &&
        write_latency inside {[1:4]} && burst_length inside {4, 8, 16}) else $error("illegal setting");
    error_pulse_a: assert property (cmd_error |=> !cmd_error)
        else $error("error flag longer than one cycle");
endmodule // lpddr_fe_monitor

bind mobile_ddr_cmd_addr_frontend lpddr_fe_monitor mon (
    .sys_clk(sys_clk), .rst(rst), .ck_t(ck_t), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .core_rd(core_rd), .core_wr(core_wr), .beat_valid(beat_valid), .beat_write(beat_write),
    .beat_byte_en(beat_byte_en), .clocks_active(clocks_active), .power_down(power_down),
    .cmd_error(cmd_error), .read_latency(read_latency), .write_latency(write_latency),
    .burst_length(burst_length)
);

/* dv/lpddr_ctrl_model.sv */
// controller model driving link clock, select, command bus and mask
// assumes sys_clk at 125 MHz; every change lands on its falling edge
`timescale 1ns/1ps

module lpddr_ctrl_model (
    // system clock
    input wire sys_clk,
    // link pins
    output reg ck_t,
    output reg ck_c,
    output reg cke,
    output reg cs_n,
    output reg [9:0] ca,
    output reg [3:0] dm
);
    time t_pos;

    initial begin
        ck_t = 0;
        ck_c = 1;
        cke = 1;
        cs_n = 1;
        ca = 10'h155;
        dm = 4'h0;
    end

    // one 80 ns link cycle; clock stands still outside these
    task cyc(input [9:0] r, input [9:0] f, input bit sel, input [3:0] m);
        cs_n = !sel;
        ca = r;
        dm = m;
        repeat (2) @(negedge sys_clk);
        ck_t = 1;
        ck_c = 0;
        t_pos = $time;
        repeat (3) @(negedge sys_clk);
        ca = f;
        repeat (2) @(negedge sys_clk);
        ck_t = 0;
        ck_c = 1;
        repeat (2) @(negedge sys_clk);
        cs_n = 1;
        ca = ~f;
        @(negedge sys_clk);
    endtask

    // deselected cycles with a changing bus
    task idle(input int n);
        repeat (n) cyc(~ca, ca, 0, dm);
    endtask
endmodule // lpddr_ctrl_model

/* dv/mobile_ddr_cmd_addr_frontend_bench.sv */
// self-checking bench for the command/address front end
// assumes the controller model and the bound monitor
`timescale 1ns/1ps
`include "lpddr_fe_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module mobile_ddr_cmd_addr_frontend_bench;
    reg sys_clk = 0;
    reg rst = 1;
    reg speed_grade = 0;
    reg dual_die = 0;
    wire ck_t, ck_c, cke, cs_n, dqs_out, dqs_oe, core_rd, core_wr, beat_valid, beat_write;
    wire clocks_active, power_down, cmd_error, burst_busy, burst_interleave;
    wire [9:0] cmd_addr_bus, core_col, beat_col;
    wire [3:0] write_byte_mask, beat_byte_en, read_latency;
    wire [2:0] core_bank, write_latency;
    wire [13:0] core_row;
    wire [4:0] burst_length;
    int n_fail = 0, cmp_count = 0, nb, ncore, nerr;
    reg [9:0] bc [16];
    reg [3:0] be [16];
    reg bw [16];
    reg [2:0] ebank, W, code;
    reg [13:0] erow;
    reg [9:0] estart;
    reg [3:0] L;
    reg [4:0] bl;
    reg il;
    time tb;

    always #4 sys_clk = ~sys_clk;

    lpddr_ctrl_model ctl (.sys_clk(sys_clk), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n),
        .ca(cmd_addr_bus), .dm(write_byte_mask));
    mobile_ddr_cmd_addr_frontend uut (
        .sys_clk(sys_clk), .rst(rst), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n),
        .cmd_addr_bus(cmd_addr_bus), .write_byte_mask(write_byte_mask), .speed_grade(speed_grade),
        .dual_die(dual_die), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .core_rd(core_rd), .core_wr(core_wr),
        .core_bank(core_bank), .core_row(core_row), .core_col(core_col), .beat_valid(beat_valid),
        .beat_write(beat_write), .beat_col(beat_col), .beat_byte_en(beat_byte_en),
        .clocks_active(clocks_active), .power_down(power_down), .cmd_error(cmd_error),
        .burst_busy(burst_busy), .read_latency(read_latency), .write_latency(write_latency),
        .burst_length(burst_length), .burst_interleave(burst_interleave));

    // beat and core capture
    always @(negedge sys_clk) begin
        if (beat_valid) begin
            `CHK(burst_busy, 1'b1)
            if (nb == 0)
                tb = $time;
            bc[nb % 16] = beat_col;
            be[nb % 16] = beat_byte_en;
            bw[nb % 16] = beat_write;
            nb++;
        end
        if (core_rd || core_wr) begin
            `CHK({core_bank, core_row, core_col}, {ebank, erow, ecol(estart, ncore * 4)})
            ncore++;
        end
        if (cmd_error)
            nerr++;
    end

    function [9:0] ecol(input [9:0] s, input int i);
        reg [9:0] m;
        m = bl - 1;
        ecol = il ? (s ^ i[9:0]) : ((s & ~m) | ((s + i[9:0]) & m));
    endfunction

    task done(input string s);
        $display("test %s ended, mismatches %0d", s, n_fail);
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task mode_reg_write(input [3:0] a, input [9:0] op);
        ctl.cyc({a, 3'h0, `OP_MRW}, op, 1, 4'h0);
        ctl.idle(2);
    endtask

    // open a random row, then read or write a burst in it
    task access(input bit wr, input bit twice);
        reg [2:0] b;
        reg [13:0] r;
        reg [9:0] c, s;
        reg [3:0] m;
        int d;
        b = $urandom;
        r = $urandom;
        c = $urandom;
        m = $urandom;
        dual_die = $urandom;
        s = dual_die ? c : c & 10'h1ff;
        nb = 0;
        ncore = 0;
        nerr = 0;
        ebank = b;
        erow = r;
        estart = s;
        ctl.cyc({r[13:10], b, `OP_ACT}, r[9:0], 1, m);
        ctl.cyc({4'h0, b, wr ? `OP_WR : `OP_RD}, c, 1, m);
        d = ctl.t_pos;
        if (twice)
            ctl.cyc({4'h0, b, `OP_RD}, c, 1, m);
        ctl.idle(11 + bl / 2);
        d = tb - d - (wr ? W : L) * 80;
        `CHK(d >= 0 && d < 80, 1'b1)
        `CHK(nb, bl)
        `CHK(ncore, bl / 4)
        `CHK(nerr, twice)
        `CHK(burst_busy, 1'b0)
        for (int i = 0; i < bl; i++) begin
            `CHK(bc[i], ecol(s, i))
            `CHK({bw[i], be[i]}, {wr, wr ? ~m : 4'hf})
        end
    endtask

    initial begin
        int rl_tab[5] = '{3, 4, 5, 6, 8};
        void'($urandom(32'h4bec));
        repeat (3) @(negedge sys_clk);
        rst = 0;
        repeat (10) @(negedge sys_clk);
        `CHK({read_latency, write_latency, burst_length, burst_interleave}, {4'h6, 3'h3, 5'h04, 1'b0})
        ctl.idle(2);
        done("reset");
        for (int k = 0; k < 12; k++) begin
            L = rl_tab[k % 5];
            W = (k + k / 4) % 4 + 1;
            code = 2 + k % 3;
            bl = 5'h04 << (k % 3);
            il = (k / 3) % 2;
            mode_reg_write(`MA_BURST, {6'h0, il, code});
            mode_reg_write(`MA_LAT, {3'h0, W, L});
            `CHK({read_latency, write_latency, burst_length, burst_interleave}, {L, W, bl, il})
            repeat ($urandom % 64) @(negedge sys_clk);
            access((k / 2) % 2, 0);
        end
        done("bursts");
        mode_reg_write(`MA_RESET, 10'h0);
        `CHK({read_latency, write_latency, burst_length, burst_interleave}, {4'h6, 3'h3, 5'h04, 1'b0})
        nerr = 0;
        nb = 0;
        ctl.cyc({4'h0, ebank, `OP_RD}, 10'h0, 1, 4'h0);
        ctl.idle(1);
        `CHK(nerr, 1)
        done("mode reset");
        speed_grade = 1;
        rst = 1;
        repeat (3) @(negedge sys_clk);
        rst = 0;
        repeat (10) @(negedge sys_clk);
        `CHK(read_latency, 4'h5)
        ctl.idle(2);
        nerr = 0;
        ctl.cyc({4'h0, 3'h5, `OP_ACT}, 10'h0, 0, 4'h0);
        ctl.cyc({4'h0, 3'h5, `OP_RD}, 10'h0, 1, 4'h0);
        ctl.cyc(10'h0, 10'h0, 1, 4'h0);
        mode_reg_write(`MA_LAT, 10'h017);
        `CHK(nerr, 3)
        `CHK(nb, 0)
        `CHK(read_latency, 4'h5)
        done("refusals");
        ctl.cke = 0;
        ctl.idle(2);
        `CHK({clocks_active, power_down}, 2'b01)
        ctl.cke = 1;
        ctl.idle(2);
        `CHK({clocks_active, power_down}, 2'b10)
        done("power down");
        L = 5;
        W = 3;
        bl = 4;
        il = 0;
        access(0, 1);
        access(1, 0);
        done("back to back");
        summarize;
    end

    initial begin
        #400_000;
        n_fail++;
        $display("watchdog expired");
        summarize;
    end
endmodule // mobile_ddr_cmd_addr_frontend_bench
